//--- shared/uhs_pkg.sv
// Package with constants and types for the UART host select, baud and clear-to-send block
package uhs_pkg;
	// ****************************************
	// Register indices (register-select value)
	// ****************************************
	localparam logic [2:0] UHS_ADDR_DIV_LO = 3'h0;
	localparam logic [2:0] UHS_ADDR_DIV_HI = 3'h1;
	localparam logic [2:0] UHS_ADDR_IER = 3'h1;
	localparam logic [2:0] UHS_ADDR_IIR = 3'h2;
	localparam logic [2:0] UHS_ADDR_LCR = 3'h3;
	localparam logic [2:0] UHS_ADDR_MSR = 3'h6;
	localparam logic [2:0] UHS_ADDR_SCR = 3'h7;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int UHS_LCR_DAB_BIT = 7;
	localparam int UHS_IER_MSI_BIT = 3;
	localparam int UHS_MSR_CTS_BIT = 4;
	localparam int UHS_MSR_DELTA_BIT = 0;
	localparam int UHS_IIR_NPEND_BIT = 0;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] UHS_RST_BYTE = 8'h00;
	localparam logic [15:0] UHS_RST_DIV = 16'h0000;
	localparam logic [15:0] UHS_DIV_ONE = 16'h0001;
	localparam logic [2:0] UHS_RST_ADDR = 3'h0;
	// Width of the bundle of pin inputs that pass the synchroniser
	localparam int UHS_SYNC_W = 19;
	// Idle pin bundle: strobe high, low-active select high, clear-to-send inactive
	localparam logic [UHS_SYNC_W-1:0] UHS_PIN_IDLE = 19'h41200;
	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [2:0] addr;
		logic cs;
	} uhs_sel_s;
	localparam uhs_sel_s UHS_RST_SEL = '{addr: UHS_RST_ADDR, cs: 1'b0};
	// Chip is selected only for the high, high, low pattern
	function automatic logic uhs_cs_decode(input logic a, input logic b, input logic low_n);
		uhs_cs_decode = a & b & ~low_n;
	endfunction : uhs_cs_decode
endpackage : uhs_pkg

//--- hdl/uhs_baud_gen.sv
// Baud divider producing the 16x baud clock output
`timescale 1ns/10ps
`default_nettype none
module uhs_baud_gen import uhs_pkg::*; (
	input wire logic clk_sys, // System clock, reference oscillator
	input wire logic rst_sync_n, // Synchronised reset, active low
	input wire logic [15:0] divisor, // Divisor latch value
	output logic baud_clk_out // 16x baud clock, one cycle high per period
);
	// ****************************************
	// Divider
	// ****************************************
	logic [15:0] cnt_r;
	logic tick;
	// Tick when the count reaches one; zero divisor stops the clock
	assign tick = (divisor != UHS_RST_DIV) && (cnt_r <= UHS_DIV_ONE || cnt_r > divisor);
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cnt_r <= UHS_RST_DIV;
		end else if (divisor == UHS_RST_DIV) begin
			cnt_r <= UHS_RST_DIV;
		end else if (tick) begin
			cnt_r <= divisor;
		end else begin
			cnt_r <= cnt_r - UHS_DIV_ONE;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			baud_clk_out <= 1'b0;
		end else begin
			baud_clk_out <= tick;
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	logic [16:0] gap_r;
	logic [15:0] div_d_r;
	logic seen_r;
	// Period check is armed only after a pulse that followed a stable divisor
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			gap_r <= 17'h00001;
			div_d_r <= UHS_RST_DIV;
			seen_r <= 1'b0;
		end else begin
			div_d_r <= divisor;
			if (baud_clk_out) begin
				gap_r <= 17'h00001;
				seen_r <= (divisor == div_d_r);
			end else begin
				gap_r <= gap_r + 17'h00001;
				if (divisor != div_d_r) begin
					seen_r <= 1'b0;
				end
			end
		end
	end
	property p_baud_period;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		baud_clk_out && seen_r && $stable(divisor) && divisor > UHS_DIV_ONE
			|-> gap_r == {1'b0, divisor};
	endproperty
	a_baud_period: assert property (p_baud_period) else $error("baud period differs from divisor");
	property p_baud_stop;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		divisor == UHS_RST_DIV [*2] |=> !baud_clk_out;
	endproperty
	a_baud_stop: assert property (p_baud_stop) else $error("baud clock runs with zero divisor");
	c_baud_tick: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
		baud_clk_out && seen_r);
endmodule : uhs_baud_gen
`default_nettype wire

//--- hdl/uhs_host_port.sv
// CPU-side select logic, data bus, baud output and clear-to-send status
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Rising edge of the address strobe latches register select; held for the access.
// - The 16x baud clock is driven on a dedicated output.
// - Baud clock rate is reference clock divided by the divisor latches.
// - Selected only for selects high, high, low; other accesses are ignored.
// - Decoded chip select is latched on the strobe's rising edge too.
// - Eight-bit data bus; drivers released whenever no read is under way.
// - Modem status bit 4 is the complement of clear-to-send.
// - Modem status bit 0 flags a clear-to-send change since the last read.
// - Clear-to-send never affects the transmitter; status only.
// - A clear-to-send status change raises an interrupt when enabled.
// - Master reset clears registers and control, but not the divisor latches.
module uhs_host_port import uhs_pkg::*; (
	input wire logic clk_sys, // System clock, 125 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic addr_strobe_n, // Address strobe, low is transparent
	input wire logic reg_sel_bit0, // Register select bit 0
	input wire logic reg_sel_bit1, // Register select bit 1
	input wire logic reg_sel_bit2, // Register select bit 2
	input wire logic chip_sel_high_a, // Chip select, active high
	input wire logic chip_sel_high_b, // Chip select, active high
	input wire logic chip_sel_low_n, // Chip select, active low
	input wire logic rd_strobe, // Read strobe, active high
	input wire logic wr_strobe, // Write strobe, active high
	input wire logic [7:0] data_in, // Data bus input side
	output logic [7:0] data_out, // Data bus output side
	output logic data_oe, // Data bus drive enable, high while driving
	input wire logic clear_to_send_n, // Clear-to-send from modem, active low
	input wire logic master_reset_in, // Master reset, active high
	output logic baud_clk_out, // 16x baud clock
	output logic modem_intr // Modem status interrupt, active high
);
	// ****************************************
	// Reset release and input synchronisers
	// ****************************************
	logic [1:0] rst_pipe_r;
	logic rst_sync_n;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_r[1];

	logic [UHS_SYNC_W-1:0] pin_s1_r;
	logic [UHS_SYNC_W-1:0] pin_s2_r;
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_s1_r <= UHS_PIN_IDLE;
			pin_s2_r <= UHS_PIN_IDLE;
		end else begin
			pin_s1_r <= {addr_strobe_n, reg_sel_bit2, reg_sel_bit1, reg_sel_bit0,
				chip_sel_high_a, chip_sel_high_b, chip_sel_low_n, rd_strobe, wr_strobe,
				clear_to_send_n, master_reset_in, data_in};
			pin_s2_r <= pin_s1_r;
		end
	end
	logic strobe_n_s, rd_s, wr_s, cts_n_s, mreset_s;
	logic [7:0] din_s;
	uhs_sel_s live;
	assign strobe_n_s = pin_s2_r[18];
	assign live = '{addr: pin_s2_r[17:15],
		cs: uhs_cs_decode(pin_s2_r[14], pin_s2_r[13], pin_s2_r[12])};
	assign rd_s = pin_s2_r[11];
	assign wr_s = pin_s2_r[10];
	assign cts_n_s = pin_s2_r[9];
	assign mreset_s = pin_s2_r[8];
	assign din_s = pin_s2_r[7:0];

	// ****************************************
	// Address strobe latch
	// ****************************************
	uhs_sel_s latch_r;
	uhs_sel_s eff;
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			latch_r <= UHS_RST_SEL;
		end else if (!strobe_n_s) begin
			latch_r <= live;
		end
	end
	// Transparent while the strobe is low, frozen after its rising edge
	assign eff = strobe_n_s ? latch_r : live;

	// ****************************************
	// Access strobes
	// ****************************************
	logic rd_d_r, wr_d_r, rd_go, wr_go, msr_read;
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_d_r <= 1'b0;
			wr_d_r <= 1'b0;
		end else begin
			rd_d_r <= rd_s;
			wr_d_r <= wr_s;
		end
	end
	assign rd_go = rd_s && !rd_d_r && eff.cs;
	assign wr_go = wr_s && !wr_d_r && eff.cs && !rd_s;

	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] lcr_r, ier_r, scr_r;
	logic [15:0] div_r;
	logic dab;
	assign dab = lcr_r[UHS_LCR_DAB_BIT];
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			lcr_r <= UHS_RST_BYTE;
			ier_r <= UHS_RST_BYTE;
			scr_r <= UHS_RST_BYTE;
		end else if (mreset_s) begin
			lcr_r <= UHS_RST_BYTE;
			ier_r <= UHS_RST_BYTE;
			scr_r <= UHS_RST_BYTE;
		end else if (wr_go) begin
			if (eff.addr == UHS_ADDR_LCR) lcr_r <= din_s;
			if (eff.addr == UHS_ADDR_IER && !dab) ier_r <= din_s;
			if (eff.addr == UHS_ADDR_SCR) scr_r <= din_s;
		end
	end
	// Divisor latches survive master reset; reached only with the access bit set
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			div_r <= UHS_RST_DIV;
		end else if (wr_go && dab) begin
			if (eff.addr == UHS_ADDR_DIV_LO) div_r[7:0] <= din_s;
			if (eff.addr == UHS_ADDR_DIV_HI) div_r[15:8] <= din_s;
		end
	end

	// ****************************************
	// Clear-to-send status and change flag
	// ****************************************
	logic cts_prev_r, cts_valid_r, delta_r, cts_change;
	assign msr_read = rd_go && eff.addr == UHS_ADDR_MSR;
	assign cts_change = cts_valid_r && (cts_n_s != cts_prev_r);
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cts_prev_r <= 1'b1;
			cts_valid_r <= 1'b0;
		end else begin
			cts_prev_r <= cts_n_s;
			cts_valid_r <= 1'b1;
		end
	end
	// A change in the cycle of the read wins over the clear
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			delta_r <= 1'b0;
		end else if (mreset_s) begin
			delta_r <= 1'b0;
		end else begin
			delta_r <= cts_change || (delta_r && !msr_read);
		end
	end
	// Clear-to-send feeds status only; nothing here reaches the transmitter
	assign modem_intr = delta_r && ier_r[UHS_IER_MSI_BIT];

	// ****************************************
	// Read data and bus drive
	// ****************************************
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = UHS_RST_BYTE;
		case (eff.addr)
			UHS_ADDR_DIV_LO: rd_mux = dab ? div_r[7:0] : UHS_RST_BYTE;
			UHS_ADDR_IER: rd_mux = dab ? div_r[15:8] : ier_r;
			UHS_ADDR_IIR: rd_mux[UHS_IIR_NPEND_BIT] = !modem_intr;
			UHS_ADDR_LCR: rd_mux = lcr_r;
			UHS_ADDR_MSR: begin
				rd_mux[UHS_MSR_CTS_BIT] = !cts_n_s;
				rd_mux[UHS_MSR_DELTA_BIT] = delta_r;
			end
			UHS_ADDR_SCR: rd_mux = scr_r;
			default: rd_mux = UHS_RST_BYTE;
		endcase
	end
	// Data is captured at the start of a read and held for its duration
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			data_out <= UHS_RST_BYTE;
		end else if (rd_go) begin
			data_out <= rd_mux;
		end
	end
	logic rd_active_r;
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_active_r <= 1'b0;
		end else begin
			rd_active_r <= rd_go || (rd_active_r && rd_s);
		end
	end
	assign data_oe = rd_active_r && rd_s;

	// ****************************************
	// Baud generator
	// ****************************************
	uhs_baud_gen u_uhs_baud_gen (
		.clk_sys(clk_sys),
		.rst_sync_n(rst_sync_n),
		.divisor(div_r),
		.baud_clk_out(baud_clk_out)
	);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_sync_n);
	property p_latch_hold;
		strobe_n_s && $past(strobe_n_s) |-> $stable(latch_r) && eff == latch_r;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched select moved");
	property p_latch_capture;
		$rose(strobe_n_s) |-> eff == $past(live);
	endproperty
	a_latch_capture: assert property (p_latch_capture) else $error("select not captured");
	property p_decode;
		!strobe_n_s |-> eff.cs == (pin_s2_r[14] && pin_s2_r[13] && !pin_s2_r[12]);
	endproperty
	a_decode: assert property (p_decode) else $error("chip select decode wrong");
	property p_no_drive;
		(!rd_s || !$past(eff.cs) && !rd_active_r) |-> !data_oe;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("bus driven outside read");
	property p_cts_bit;
		msr_read |=> data_out[UHS_MSR_CTS_BIT] == !$past(cts_n_s);
	endproperty
	a_cts_bit: assert property (p_cts_bit) else $error("status bit 4 wrong");
	property p_delta_set;
		cts_change && !mreset_s |=> delta_r [*2] or (delta_r ##1 $past(msr_read));
	endproperty
	a_delta_set: assert property (p_delta_set) else $error("change flag not set");
	property p_delta_clear;
		msr_read && !cts_change |=> !delta_r;
	endproperty
	a_delta_clear: assert property (p_delta_clear) else $error("change flag not cleared");
	property p_delta_cause;
		$rose(delta_r) |-> $past(cts_n_s) != $past(cts_prev_r, 1);
	endproperty
	a_delta_cause: assert property (p_delta_cause) else $error("flag set without change");
	property p_intr;
		cts_change && !mreset_s && ier_r[UHS_IER_MSI_BIT] && !wr_go |=> modem_intr;
	endproperty
	a_intr: assert property (p_intr) else $error("interrupt missing");
	property p_master_reset;
		mreset_s ##1 mreset_s |-> lcr_r == UHS_RST_BYTE && ier_r == UHS_RST_BYTE && !delta_r
			&& div_r == $past(div_r);
	endproperty
	a_master_reset: assert property (p_master_reset) else $error("master reset effect wrong");
	c_latched_read: cover property ($rose(strobe_n_s) ##[1:20] rd_go);
	c_msr_clear: cover property (delta_r && msr_read);
	c_intr: cover property ($rose(modem_intr));
	c_div_write: cover property (wr_go && dab);
endmodule : uhs_host_port
`default_nettype wire

//--- dv/uhs_modem_model.sv
// Modem-side model driving the clear-to-send line
`timescale 1ns/10ps
`default_nettype none
module uhs_modem_model (
	input wire logic clk_sys, // Clock used to time line changes
	input wire logic ready_req, // Bench asks the modem to signal ready
	output logic clear_to_send_n // Clear-to-send line, active low
);
	initial clear_to_send_n = 1'b1;
	// Line changes a little after the edge, unrelated to the device sampling
	always @(posedge clk_sys) begin
		clear_to_send_n <= #1 ~ready_req;
	end
endmodule : uhs_modem_model
`default_nettype wire

//--- dv/tb_uart_host_select_baud_cts.sv
// Self-checking testbench for the host select, baud and clear-to-send block
`timescale 1ns/10ps
`default_nettype none
module tb_uart_host_select_baud_cts;
	import uhs_pkg::*;
	logic clk_sys = 1'b0, rst_n = 1'b0, addr_strobe_n = 1'b0;
	logic reg_sel_bit0 = 1'b0, reg_sel_bit1 = 1'b0, reg_sel_bit2 = 1'b0;
	logic chip_sel_high_a = 1'b0, chip_sel_high_b = 1'b0, chip_sel_low_n = 1'b1;
	logic rd_strobe = 1'b0, wr_strobe = 1'b0, master_reset_in = 1'b0, ready_req = 1'b0;
	logic [7:0] host_d = 8'h00, data_out, data_in, scr, dv;
	logic data_oe, clear_to_send_n, baud_clk_out, modem_intr, rclk;
	logic [31:0] seed = 32'h65896CDA;
	int num_errors = 0, n_tests = 0;
	// Shared data bus resolved from both drivers
	assign data_in = data_oe ? data_out : host_d;
	// Receiver clock of the board taken from the baud output
	assign rclk = baud_clk_out;
	always #4 clk_sys = ~clk_sys;
	uhs_host_port u_uhs_host_port (.clk_sys(clk_sys), .rst_n(rst_n),
		.addr_strobe_n(addr_strobe_n), .reg_sel_bit0(reg_sel_bit0),
		.reg_sel_bit1(reg_sel_bit1), .reg_sel_bit2(reg_sel_bit2),
		.chip_sel_high_a(chip_sel_high_a), .chip_sel_high_b(chip_sel_high_b),
		.chip_sel_low_n(chip_sel_low_n), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.clear_to_send_n(clear_to_send_n), .master_reset_in(master_reset_in),
		.baud_clk_out(baud_clk_out), .modem_intr(modem_intr));
	uhs_modem_model u_uhs_modem_model (.clk_sys(clk_sys), .ready_req(ready_req),
		.clear_to_send_n(clear_to_send_n));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [7:0] msr_exp(input logic cts_n, input logic dlt);
		msr_exp = 8'h00;
		msr_exp[UHS_MSR_CTS_BIT] = ~cts_n;
		msr_exp[UHS_MSR_DELTA_BIT] = dlt;
	endfunction : msr_exp
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask : chk
	// One strobe pulse with address, selects {a, b, low_n} and write data
	task automatic acc(input logic wr, input logic [2:0] a, input logic [2:0] cs,
		input logic [7:0] d, output logic [7:0] q, output logic oe);
		{reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = a;
		{chip_sel_high_a, chip_sel_high_b, chip_sel_low_n} = cs;
		host_d = d;
		if (wr) wr_strobe = 1'b1;
		else rd_strobe = 1'b1;
		cyc(4);
		q = data_out;
		oe = data_oe;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
		cyc(4);
	endtask : acc
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic [2:0] cs = 3'b110);
		logic [7:0] q;
		logic oe;
		acc(1'b1, a, cs, d, q, oe);
	endtask : wr
	task automatic rd(input string nm, input logic [2:0] a, input logic [7:0] exp,
		input logic [2:0] cs = 3'b110);
		logic [7:0] q;
		logic oe;
		acc(1'b0, a, cs, ~exp, q, oe);
		chk({nm, "_oe"}, {7'h00, cs == 3'b110}, {7'h00, oe});
		if (cs == 3'b110) chk(nm, exp, q);
		chk("oe_idle", 8'h00, {7'h00, data_oe});
	endtask : rd
	task automatic baud(input logic [7:0] exp);
		int n;
		n = 0;
		while (rclk !== 1'b1 && n < 600) begin
			cyc(1);
			n++;
		end
		cyc(1);
		n = 1;
		while (rclk !== 1'b1 && n < 600) begin
			cyc(1);
			n++;
		end
		chk("baud_period", exp, n[7:0]);
	endtask : baud
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		results();
	end
	initial begin
		cyc(4);
		rst_n = 1'b1;
		cyc(6);
		rd("msr_reset", UHS_ADDR_MSR, msr_exp(1'b1, 1'b0));
		for (int i = 0; i < 6; i++) begin
			scr = 8'(xs());
			wr(UHS_ADDR_SCR, scr);
			rd("scratch", UHS_ADDR_SCR, scr);
		end
		for (int c = 0; c < 8; c++) begin
			if (c != 6) begin
				wr(UHS_ADDR_SCR, ~scr, c[2:0]);
				rd("unsel", UHS_ADDR_SCR, scr, c[2:0]);
			end
		end
		rd("scr_kept", UHS_ADDR_SCR, scr);
		// Latched select: register select pins go wrong after the strobe rises
		{reg_sel_bit2, reg_sel_bit1, reg_sel_bit0} = UHS_ADDR_SCR;
		{chip_sel_high_a, chip_sel_high_b, chip_sel_low_n} = 3'b110;
		cyc(3);
		addr_strobe_n = 1'b1;
		cyc(3);
		rd("latched", 3'h0, scr, 3'b110);
		addr_strobe_n = 1'b0;
		cyc(3);
		dv = 8'((xs() % 32) + 2);
		wr(UHS_ADDR_LCR, 8'h80);
		wr(UHS_ADDR_DIV_LO, dv);
		wr(UHS_ADDR_DIV_HI, 8'h00);
		rd("div_lo", UHS_ADDR_DIV_LO, dv);
		wr(UHS_ADDR_LCR, 8'h00);
		wr(UHS_ADDR_IER, 8'h08);
		cyc(80);
		baud(dv);
		ready_req = 1'b1;
		cyc(8);
		chk("intr_on", 8'h01, {7'h00, modem_intr});
		rd("iir_pend", UHS_ADDR_IIR, 8'h00);
		rd("msr_delta", UHS_ADDR_MSR, msr_exp(1'b0, 1'b1));
		chk("intr_off", 8'h00, {7'h00, modem_intr});
		rd("iir_idle", UHS_ADDR_IIR, 8'h01);
		rd("msr_once", UHS_ADDR_MSR, msr_exp(1'b0, 1'b0));
		ready_req = 1'b0;
		cyc(8);
		rd("msr_back", UHS_ADDR_MSR, msr_exp(1'b1, 1'b1));
		wr(UHS_ADDR_LCR, 8'h03);
		ready_req = 1'b1;
		master_reset_in = 1'b1;
		cyc(5);
		master_reset_in = 1'b0;
		cyc(5);
		chk("intr_mreset", 8'h00, {7'h00, modem_intr});
		rd("lcr_mreset", UHS_ADDR_LCR, 8'h00);
		rd("scr_mreset", UHS_ADDR_SCR, 8'h00);
		cyc(80);
		baud(dv);
		results();
	end
endmodule : tb_uart_host_select_baud_cts
`default_nettype wire
